// [logic/pmg_defs.vh]
// Register offsets, field positions, reset values and encodings for the proximity/gesture configuration block
`ifndef PMG_DEFS_VH
`define PMG_DEFS_VH
// Register indices and byte addresses (byte address is index times four)
`define PMG_IDX_OFFSET_DL 8'h9e
`define PMG_IDX_PD_CONFIG 8'h9f
`define PMG_IDX_ENTRY_TH 8'ha0
`define PMG_IDX_EXIT_TH 8'ha1
`define PMG_ADDR_OFFSET_DL 12'h278
`define PMG_ADDR_PD_CONFIG 12'h27c
`define PMG_ADDR_ENTRY_TH 12'h280
`define PMG_ADDR_EXIT_TH 12'h284
// Extra registers for loose control and status bits
`define PMG_ADDR_CONTROL 12'h300
`define PMG_ADDR_STATUS 12'h304
`define PMG_ADDR_EXIT_PERS 12'h308
`define PMG_ADDR_ADJ_PROX 12'h30c
`define PMG_ADDR_WIDTH 12
// Field positions in the photodiode selection register
`define PMG_BIT_PAIR_GAIN 5
`define PMG_BIT_SLEEP_AFTER_INT 4
`define PMG_BIT_MASK_UP 3
`define PMG_BIT_MASK_DOWN 2
`define PMG_BIT_MASK_LEFT 1
`define PMG_BIT_MASK_RIGHT 0
// Control register bits
`define PMG_BIT_GESTURE_OP 0
`define PMG_BIT_INT_CLEAR 1
// Reset values
`define PMG_RST_BYTE 8'h00
// Answer codes
`define PMG_RESP_OKAY 2'b00
`define PMG_RESP_SLVERR 2'b10
`endif

// [logic/pmg_gesture_fsm.v]
// Gesture entry/exit decision with exit persistence counting
`timescale 1ns/1ps
`default_nettype none
module pmg_gesture_fsm (
   input wire aclk,
   input wire aresetn,
   input wire sample_valid,
   input wire [7:0] proximity_result,
   input wire [9:0] gesture_exit_level,
   input wire [7:0] gesture_entry_threshold,
   input wire [7:0] gesture_exit_threshold,
   input wire [1:0] gesture_exit_persistence,
   input wire gesture_operation_bit,
   output reg gesture_active,
   output reg [2:0] end_count
);
   localparam ST_IDLE = 1'b0;
   localparam ST_GESTURE = 1'b1;

   reg [2:0] needed;
   wire end_seen;

   // Persistence field mapped to 1, 2, 4 or 7 consecutive ends
   always @* begin
      case (gesture_exit_persistence)
         2'd0: needed = 3'd1;
         2'd1: needed = 3'd2;
         2'd2: needed = 3'd4;
         default: needed = 3'd7;
      endcase
   end

   // Zero threshold never produces an end
   assign end_seen = (gesture_exit_threshold != 8'h00)
                   && (gesture_exit_level < {2'b00, gesture_exit_threshold});

   // One qualifying sample enters; no persistence on entry
   always @(posedge aclk) begin
      if (!aresetn) begin
         gesture_active <= ST_IDLE;
         end_count <= 3'd0;
      end else if (!gesture_operation_bit) begin
         gesture_active <= ST_IDLE;
         end_count <= 3'd0;
      end else if (sample_valid) begin
         case (gesture_active)
            ST_IDLE: begin
               end_count <= 3'd0;
               if (proximity_result >= gesture_entry_threshold) begin
                  gesture_active <= ST_GESTURE;
               end
            end
            ST_GESTURE: begin
               if (!end_seen) begin
                  end_count <= 3'd0;
               end else if (end_count + 3'd1 >= needed) begin
                  gesture_active <= ST_IDLE;
                  end_count <= 3'd0;
               end else begin
                  end_count <= end_count + 3'd1;
               end
            end
            default: begin
               gesture_active <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // pmg_gesture_fsm
`default_nettype wire

// [logic/pmg_offset_apply.v]
// Sign/magnitude offset correction and pair-gain scaling of the proximity signal
`timescale 1ns/1ps
`default_nettype none
module pmg_offset_apply (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] raw_up,
   input wire [7:0] raw_down,
   input wire [7:0] raw_left,
   input wire [7:0] raw_right,
   input wire [3:0] diode_mask_bits,
   input wire pair_gain,
   input wire [7:0] down_left_offset_factor,
   output reg [7:0] proximity_result
);
   wire [8:0] pair_ur;
   wire [8:0] pair_dl;
   wire [10:0] corrected;
   wire [11:0] gained;
   reg [7:0] next_result;

   // Each pair sums its unmasked diodes; masked ones contribute nothing
   assign pair_ur = {1'b0, (diode_mask_bits[3] ? 8'h00 : raw_up)}
                  + {1'b0, (diode_mask_bits[0] ? 8'h00 : raw_right)};
   assign pair_dl = {1'b0, (diode_mask_bits[2] ? 8'h00 : raw_down)}
                  + {1'b0, (diode_mask_bits[1] ? 8'h00 : raw_left)};

   // Sign bit selects subtraction of the 7-bit magnitude from the sum of both pairs
   assign corrected = down_left_offset_factor[7] ?
      ({2'b00, pair_ur} + {2'b00, pair_dl} - {4'h0, down_left_offset_factor[6:0]}) :
      ({2'b00, pair_ur} + {2'b00, pair_dl} + {4'h0, down_left_offset_factor[6:0]});

   // Doubling makes up for the half signal of a single-diode pair
   assign gained = pair_gain ? {corrected, 1'b0} : {1'b0, corrected};

   // Clamp at both ends so a large negative offset cannot wrap
   always @* begin
      if (down_left_offset_factor[7] && ({2'b00, pair_ur} + {2'b00, pair_dl}
          < {4'h0, down_left_offset_factor[6:0]})) begin
         next_result = 8'h00;
      end else if (gained > 12'h0ff) begin
         next_result = 8'hff;
      end else begin
         next_result = gained[7:0];
      end
   end

   // Unsigned 8-bit result held in a flop
   always @(posedge aclk) begin
      if (!aresetn) begin
         proximity_result <= 8'h00;
      end else begin
         proximity_result <= next_result;
      end
   end
endmodule // pmg_offset_apply
`default_nettype wire

// [logic/pmg_top.v]
// Proximity mask, offset and gesture threshold configuration block with AXI4-Lite registers
// Notes on behaviour
// - Down/left offset is sign/magnitude: bit 7 sign, low seven bits magnitude.
// - Up+right form one diode pair, down+left the other, both feed proximity.
// - A diode whose mask bit is one is left out of proximity.
// - Pair-gain bit 5 doubles the proximity signal.
// - Sleep-after-interrupt bit 4 sends device to low power at decision point.
// - Low power is left only when the host clears the interrupt.
// - Proximity result compared to entry threshold to start a gesture.
// - Persistence filter not used for gesture entry; one compare suffices.
// - Unmasked gesture diode data compared to exit threshold for gesture end.
// - Exit only after the exit persistence count of gesture ends.
// - Exit threshold zero never exits; gesture stays until mode bit cleared.
// - Persistence values 0..3 need 1st, 2nd, 4th, 7th consecutive end.
// - Proximity result is an unsigned 8-bit value.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pmg_defs.vh"
module pmg_top (
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Photodiode samples from the front end
   input wire [7:0] diode_up,
   input wire [7:0] diode_down,
   input wire [7:0] diode_left,
   input wire [7:0] diode_right,
   input wire sample_valid,
   // Interrupt pin level and sleep decision point from the device state machine
   input wire interrupt_pin,
   input wire sleep_decision,
   // Outputs to the device
   output wire [7:0] proximity_result,
   output wire gesture_active,
   output reg low_power
);
   reg [7:0] down_left_offset_factor;
   reg [7:0] photodiode_select_config;
   reg [7:0] gesture_entry_threshold;
   reg [7:0] gesture_exit_threshold;
   reg [1:0] gesture_exit_persistence;
   reg gesture_operation_bit;
   reg int_seen;
   reg aw_held;
   reg w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [7:0] sync_up_a, sync_up_b, sync_dn_a, sync_dn_b;
   reg [7:0] sync_lf_a, sync_lf_b, sync_rt_a, sync_rt_b;
   reg [2:0] sync_ctl_a, sync_ctl_b;
   reg [9:0] gesture_exit_level;
   wire [3:0] diode_mask_bits;
   wire [2:0] end_count;
   wire do_write;
   wire clear_int_write;

   // Decode used by both read and write paths
   function is_mapped;
      input [11:0] addr;
      begin
         case (addr)
            `PMG_ADDR_OFFSET_DL, `PMG_ADDR_PD_CONFIG, `PMG_ADDR_ENTRY_TH, `PMG_ADDR_EXIT_TH,
            `PMG_ADDR_CONTROL, `PMG_ADDR_STATUS, `PMG_ADDR_EXIT_PERS, `PMG_ADDR_ADJ_PROX:
               is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   assign diode_mask_bits = photodiode_select_config[`PMG_BIT_MASK_UP:`PMG_BIT_MASK_RIGHT];

   // Front-end pins come from another domain: two flops each before use
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync_up_a <= 8'h00;
         sync_up_b <= 8'h00;
         sync_dn_a <= 8'h00;
         sync_dn_b <= 8'h00;
         sync_lf_a <= 8'h00;
         sync_lf_b <= 8'h00;
         sync_rt_a <= 8'h00;
         sync_rt_b <= 8'h00;
         sync_ctl_a <= 3'b000;
         sync_ctl_b <= 3'b000;
      end else begin
         sync_up_a <= diode_up;
         sync_up_b <= sync_up_a;
         sync_dn_a <= diode_down;
         sync_dn_b <= sync_dn_a;
         sync_lf_a <= diode_left;
         sync_lf_b <= sync_lf_a;
         sync_rt_a <= diode_right;
         sync_rt_b <= sync_rt_a;
         sync_ctl_a <= {sample_valid, interrupt_pin, sleep_decision};
         sync_ctl_b <= sync_ctl_a;
      end
   end

   // Gesture exit sum uses the same mask bits as proximity
   always @(posedge aclk) begin
      if (!aresetn) begin
         gesture_exit_level <= 10'h000;
      end else begin
         gesture_exit_level <= {2'b00, (diode_mask_bits[3] ? 8'h00 : sync_up_b)}
                             + {2'b00, (diode_mask_bits[2] ? 8'h00 : sync_dn_b)}
                             + {2'b00, (diode_mask_bits[1] ? 8'h00 : sync_lf_b)}
                             + {2'b00, (diode_mask_bits[0] ? 8'h00 : sync_rt_b)};
      end
   end

   pmg_offset_apply u_offset (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw_up(sync_up_b),
      .raw_down(sync_dn_b),
      .raw_left(sync_lf_b),
      .raw_right(sync_rt_b),
      .diode_mask_bits(diode_mask_bits),
      .pair_gain(photodiode_select_config[`PMG_BIT_PAIR_GAIN]),
      .down_left_offset_factor(down_left_offset_factor),
      .proximity_result(proximity_result)
   );

   pmg_gesture_fsm u_gesture (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_valid(sync_ctl_b[2]),
      .proximity_result(proximity_result),
      .gesture_exit_level(gesture_exit_level),
      .gesture_entry_threshold(gesture_entry_threshold),
      .gesture_exit_threshold(gesture_exit_threshold),
      .gesture_exit_persistence(gesture_exit_persistence),
      .gesture_operation_bit(gesture_operation_bit),
      .gesture_active(gesture_active),
      .end_count(end_count)
   );

   // Address and data are caught independently, in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign clear_int_write = do_write && (aw_addr == `PMG_ADDR_CONTROL) && w_strb[0]
                          && w_data[`PMG_BIT_INT_CLEAR];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMG_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (is_mapped(aw_addr) && aw_addr != `PMG_ADDR_STATUS
                           && aw_addr != `PMG_ADDR_ADJ_PROX) ? `PMG_RESP_OKAY : `PMG_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; only byte lane 0 carries data
   always @(posedge aclk) begin
      if (!aresetn) begin
         down_left_offset_factor <= `PMG_RST_BYTE;
         photodiode_select_config <= `PMG_RST_BYTE;
         gesture_entry_threshold <= `PMG_RST_BYTE;
         gesture_exit_threshold <= `PMG_RST_BYTE;
         gesture_exit_persistence <= 2'b00;
         gesture_operation_bit <= 1'b0;
      end else if (do_write && w_strb[0]) begin
         case (aw_addr)
            `PMG_ADDR_OFFSET_DL: down_left_offset_factor <= w_data[7:0];
            `PMG_ADDR_PD_CONFIG: photodiode_select_config <= w_data[7:0]; // Reserved bits stored as written
            `PMG_ADDR_ENTRY_TH: gesture_entry_threshold <= w_data[7:0];
            `PMG_ADDR_EXIT_TH: gesture_exit_threshold <= w_data[7:0];
            `PMG_ADDR_EXIT_PERS: gesture_exit_persistence <= w_data[1:0];
            `PMG_ADDR_CONTROL: gesture_operation_bit <= w_data[`PMG_BIT_GESTURE_OP];
            default: begin
            end
         endcase
      end
   end

   // Low power: enter at the decision point once an interrupt has been seen, leave on host clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_power <= 1'b0;
         int_seen <= 1'b0;
      end else begin
         if (clear_int_write) begin
            int_seen <= 1'b0;
            low_power <= 1'b0;
         end else begin
            if (photodiode_select_config[`PMG_BIT_SLEEP_AFTER_INT] && (int_seen || sync_ctl_b[1])
                && sync_ctl_b[0]) begin
               low_power <= 1'b1;
            end
         end
         // An interrupt still up in the clear cycle is kept
         if (sync_ctl_b[1]) begin
            int_seen <= 1'b1;
         end
      end
   end

   // Reads answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PMG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped({s_axi_araddr[11:2], 2'b00}) ? `PMG_RESP_OKAY : `PMG_RESP_SLVERR;
         case ({s_axi_araddr[11:2], 2'b00})
            `PMG_ADDR_OFFSET_DL: s_axi_rdata <= {24'h00_0000, down_left_offset_factor};
            `PMG_ADDR_PD_CONFIG: s_axi_rdata <= {24'h00_0000, photodiode_select_config};
            `PMG_ADDR_ENTRY_TH: s_axi_rdata <= {24'h00_0000, gesture_entry_threshold};
            `PMG_ADDR_EXIT_TH: s_axi_rdata <= {24'h00_0000, gesture_exit_threshold};
            `PMG_ADDR_CONTROL: s_axi_rdata <= {31'h0000_0000, gesture_operation_bit};
            `PMG_ADDR_STATUS: s_axi_rdata <= {27'h000_0000, end_count, low_power, gesture_active};
            `PMG_ADDR_EXIT_PERS: s_axi_rdata <= {30'h0000_0000, gesture_exit_persistence};
            `PMG_ADDR_ADJ_PROX: s_axi_rdata <= {24'h00_0000, proximity_result};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // pmg_top
`default_nettype wire

// [tb/pmg_host_model.sv]
// Host controller model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module pmg_host_model (
   input wire logic aclk,
   output var logic [11:0] s_axi_awaddr,
   output var logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output var logic [31:0] s_axi_wdata,
   output var logic [3:0] s_axi_wstrb,
   output var logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output var logic s_axi_bready,
   output var logic [11:0] s_axi_araddr,
   output var logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output var logic s_axi_rready
);
   // Quiet bus at time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end
   // Write; reserved bits forced low as a well-behaved host would
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic [7:0] v;
      v = d;
      if (a == 12'h027c) v[7:6] = 2'b00;
      if (a == 12'h0280) v[4] = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      s_axi_awaddr <= ~a;
      s_axi_wdata <= ~s_axi_wdata;
   endtask
   // Read; stale address inverted so nothing leans on it
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
   endtask
endmodule // pmg_host_model
`default_nettype wire

// [tb/pmg_top_props.sv]
// Concurrent checks on the configuration block ports
`timescale 1ns/1ps
`default_nettype none
module pmg_top_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_valid,
   input wire logic sleep_decision,
   input wire logic gesture_active,
   input wire logic low_power
);
   logic [5:0] sd_hist;
   logic [5:0] sv_hist;
   logic ar_ok;
   // Mapped read places; anything else must answer with an error
   assign ar_ok = {s_axi_araddr[11:2], 2'b00} inside {12'h0278, 12'h027c, 12'h0280, 12'h0284,
                                                     12'h0300, 12'h0304, 12'h0308, 12'h030c};
   // Input history, deep enough to cover the two-flop synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sd_hist <= 6'h00;
         sv_hist <= 6'h00;
      end else begin
         sd_hist <= {sd_hist[4:0], sleep_decision};
         sv_hist <= {sv_hist[4:0], sample_valid};
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && !ar_ok |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_sleep_cause: assert property ($rose(low_power) |-> |sd_hist)
      else $error("low power without sleep decision");
   chk_entry_cause: assert property ($rose(gesture_active) |-> |sv_hist)
      else $error("gesture entered without a sample");
   cover property ($rose(low_power));
   cover property ($fell(gesture_active));
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // pmg_top_props
bind pmg_top pmg_top_props pmg_top_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid, .sleep_decision, .gesture_active,
   .low_power);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the proximity and gesture configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] diode_up = 8'h00, diode_down = 8'h00, diode_left = 8'h00, diode_right = 8'h00;
   logic sample_valid = 1'b0, interrupt_pin = 1'b0, sleep_decision = 1'b0;
   wire [11:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   wire [7:0] proximity_result;
   wire gesture_active, low_power;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   int n, v;
   int mreg [4];
   int pers_q [$] = '{1, 2, 4, 7};
   logic [11:0] addr_tab [4] = '{12'h0278, 12'h027c, 12'h0280, 12'h0284};
   logic [7:0] off_tab [6] = '{8'h7f, 8'h01, 8'h00, 8'h81, 8'hff, 8'h40};
   logic [31:0] rdat;
   logic [1:0] resp;

   pmg_top pmg_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .diode_up(diode_up),
      .diode_down(diode_down), .diode_left(diode_left), .diode_right(diode_right), .sample_valid(sample_valid),
      .interrupt_pin(interrupt_pin), .sleep_decision(sleep_decision), .proximity_result(proximity_result),
      .gesture_active(gesture_active), .low_power(low_power));
   pmg_host_model pmg_host_model_inst (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   always #12.5 aclk = ~aclk;

   // Hang guard, well above the several hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim;
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic w(input logic [11:0] a, input logic [7:0] d);
      pmg_host_model_inst.wr(a, d, resp);
      chk("write resp", 32'(resp), 32'h0000_0000);
   endtask
   // One synced sample, then time for the decision to land
   task automatic sample;
      @(posedge aclk);
      sample_valid <= 1'b1;
      @(posedge aclk);
      sample_valid <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
   // Offset on a zero base: negative clamps to zero, gain doubles
   function automatic int exp_prox(int off, int gain);
      int r;
      r = (off & 128) ? 0 : off & 127;
      if (gain != 0) r = r * 2;
      return r;
   endfunction

   initial begin
      void'($urandom(19));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, then an unmapped place
      for (int i = 0; i < 4; i++) begin
         pmg_host_model_inst.rd(addr_tab[i], rdat, resp);
         chk("reset value", rdat, 32'h0000_0000);
         chk("read resp", 32'(resp), 32'h0000_0000);
      end
      pmg_host_model_inst.rd(12'h03f0, rdat, resp);
      chk("unmapped resp", 32'(resp), 32'h0000_0002);
      pmg_host_model_inst.wr(12'h0304, 8'hff, resp);
      chk("read-only write resp", 32'(resp), 32'h0000_0002);
      // Random write and read back
      for (int i = 0; i < 4; i++) begin
         v = $urandom & 255;
         mreg[i] = (i == 1) ? v & 63 : (i == 2) ? v & 239 : v;
         w(addr_tab[i], v[7:0]);
         pmg_host_model_inst.rd(addr_tab[i], rdat, resp);
         chk("readback", rdat, 32'(mreg[i]));
      end
      // Masked diodes carry random data that must not show
      diode_up <= 8'($urandom);
      diode_down <= 8'($urandom);
      diode_left <= 8'($urandom);
      diode_right <= 8'($urandom);
      for (int g = 0; g < 2; g++) begin
         w(12'h027c, g ? 8'h27 : 8'h0f);
         if (g) diode_up <= 8'h00;
         foreach (off_tab[k]) begin
            w(12'h0278, off_tab[k]);
            repeat (6) @(posedge aclk);
            chk("proximity", 32'(proximity_result), 32'(exp_prox(off_tab[k], g)));
         end
      end
      // Gesture entry on one sample, no exit at zero threshold
      w(12'h027c, 8'h0f);
      w(12'h0280, 8'h20);
      w(12'h0284, 8'h00);
      w(12'h0300, 8'h01);
      w(12'h0278, 8'h1f);
      sample;
      chk("below entry", 32'(gesture_active), 32'h0000_0000);
      w(12'h0278, 8'h20);
      sample;
      chk("at entry", 32'(gesture_active), 32'h0000_0001);
      w(12'h0278, 8'h00);
      repeat (8) sample;
      chk("zero exit level", 32'(gesture_active), 32'h0000_0001);
      w(12'h0300, 8'h00);
      repeat (6) @(posedge aclk);
      chk("mode cleared", 32'(gesture_active), 32'h0000_0000);
      // Exit persistence for every code
      w(12'h0284, 8'h01);
      w(12'h0300, 8'h01);
      for (int p = 0; p < 4; p++) begin
         w(12'h0308, p[7:0]);
         w(12'h0278, 8'h20);
         sample;
         w(12'h0278, 8'h00);
         n = 0;
         while (gesture_active === 1'b1 && n < 10) begin
            sample;
            n++;
         end
         chk("exit count", 32'(n), 32'(pers_q[p]));
      end
      // Unmasked diode above exit threshold holds the gesture, its drop ends it
      w(12'h027c, 8'h27);
      w(12'h0308, 8'h00);
      diode_up <= 8'h40;
      repeat (2) sample;
      chk("unmasked level", 32'(gesture_active), 32'h0000_0001);
      diode_up <= 8'h00;
      sample;
      chk("level end", 32'(gesture_active), 32'h0000_0000);
      // Sleep after interrupt, held until the host clears it
      w(12'h027c, 8'h1f);
      interrupt_pin <= 1'b1;
      sleep_decision <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("sleep entered", 32'(low_power), 32'h0000_0001);
      interrupt_pin <= 1'b0;
      sleep_decision <= 1'b0;
      repeat (6) @(posedge aclk);
      chk("sleep held", 32'(low_power), 32'h0000_0001);
      w(12'h0300, 8'h02);
      repeat (4) @(posedge aclk);
      chk("sleep cleared", 32'(low_power), 32'h0000_0000);
      w(12'h027c, 8'h0f);
      interrupt_pin <= 1'b1;
      sleep_decision <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("sleep disabled", 32'(low_power), 32'h0000_0000);
      end_sim;
   end
endmodule // tb
`default_nettype wire
